/* verilog/osc_pkg.sv */
// Shared constants and types of the configuration store
package osc_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int CFG_BITS = 56;
    localparam int REC_DATA = 28;
    localparam int REC_PAR = 4;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_REC_LOW = 8'h0c;
    localparam logic [7:0] OFS_REC_HIGH = 8'h10;
    localparam logic [7:0] OFS_SHD_LOW = 8'h14;
    localparam logic [7:0] OFS_SHD_HIGH = 8'h18;
    localparam logic [7:0] OFS_FUSE_LOW = 8'h1c;
    localparam logic [7:0] OFS_FUSE_HIGH = 8'h20;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_RD_MODE = 0;
    localparam logic CTRL_RD_RST = 1'b0;
    localparam int STAT_LOCK = 0;
    localparam int STAT_SRC_SHD = 1;
    localparam int STAT_REJECT = 2;
    localparam int STAT_TEST = 3;
    localparam int STAT_PRECH = 4;
    localparam int CMD_OP_LSB = 6;
    localparam logic [7:0] CMD_RST = 8'h00;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------
    // Configuration bit addresses
    // ------------------------------------------------------------
    localparam logic [5:0] ADR_LOCK = 6'h00;
    localparam logic [5:0] ADR_CLK_RANGE = 6'h01;
    localparam logic [5:0] ADR_OSC_TYPE = 6'h02;
    localparam logic [5:0] ADR_MODE_LSB = 6'h03;
    localparam logic [5:0] ADR_MODE_MSB = 6'h04;
    localparam logic [5:0] ADR_PSRC_LSB = 6'h30;
    localparam logic [5:0] ADR_PSRC_MSB = 6'h31;

    // ------------------------------------------------------------
    // Commands and modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_PRECHARGE = 2'h0,
        OP_SHADOW = 2'h1,
        OP_FUSE = 2'h2,
        OP_RRESET = 2'h3
    } osc_op_type;

    typedef enum logic [1:0] {
        MODE_PERI_WDG = 2'h0,
        MODE_PERI_SD = 2'h1,
        MODE_STAND_AW = 2'h2,
        MODE_STAND_SEL = 2'h3
    } osc_mode_type;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic watchdog;
        logic zero_crossing_out;
        logic energy_pulse;
        logic sd_voltage;
        logic sd_current;
        logic mux_sel;
        logic step_pos;
        logic step_neg;
        logic no_load;
        logic tamper;
        logic neg_power;
        logic [3:0] pulse_src;
    } osc_src_type;

    typedef struct packed {
        logic positive_output_pin;
        logic negative_output_pin;
        logic pulse_output_pin;
        logic clock_noload_pin;
        logic data_tamper_pin;
        logic direction_flag_pin;
    } osc_pin_type;

endpackage

/* verilog/osc_pin_mux.sv */
// Output pin routing by operating mode
`timescale 1ns/1ps
module osc_pin_mux (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclken,
    input wire logic [1:0] mode,
    input wire logic [1:0] psrc,
    input wire osc_pkg::osc_src_type src,
    output osc_pkg::osc_pin_type pins
);

    osc_pkg::osc_pin_type pins_r;
    osc_pkg::osc_pin_type pins_nxt;

    // ------------------------------------------------------------
    // Routing
    // ------------------------------------------------------------
    always_comb begin
        pins_nxt = '0;
        unique case (osc_pkg::osc_mode_type'(mode))
            // (RQ14) Watchdog, zero crossing
            osc_pkg::MODE_PERI_WDG: begin
                pins_nxt.negative_output_pin = src.watchdog;
                pins_nxt.positive_output_pin = src.zero_crossing_out;
                pins_nxt.pulse_output_pin = src.energy_pulse;
            end
            // (RQ15) Sigma-delta streams
            osc_pkg::MODE_PERI_SD: begin
                pins_nxt.positive_output_pin = src.sd_voltage;
                pins_nxt.negative_output_pin = src.sd_current;
                pins_nxt.pulse_output_pin = src.mux_sel;
            end
            osc_pkg::MODE_STAND_AW, osc_pkg::MODE_STAND_SEL: begin
                // (RQ16) Stepper and flags
                pins_nxt.positive_output_pin = src.step_pos;
                pins_nxt.negative_output_pin = src.step_neg;
                pins_nxt.clock_noload_pin = src.no_load;
                pins_nxt.data_tamper_pin = src.tamper;
                pins_nxt.direction_flag_pin = src.neg_power;
                // (RQ17) Pulse source choice
                pins_nxt.pulse_output_pin = mode[0] ? src.pulse_src[psrc]
                                                    : src.energy_pulse;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_r <= '0;
        end else if (pclken) begin
            pins_r <= pins_nxt;
        end
    end

    assign pins = pins_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_mode0_pins;
        @(posedge pclk) disable iff (!presetn)
        (pclken && mode == 2'h0) |=> pins.negative_output_pin == $past(src.watchdog)
            && pins.positive_output_pin == $past(src.zero_crossing_out);
    endproperty
    a_mode0_pins: assert property (p_mode0_pins) else $error("mode 0 pins wrong"); // RQ14

    property p_mode1_pins;
        @(posedge pclk) disable iff (!presetn)
        (pclken && mode == 2'h1) |=> pins.pulse_output_pin == $past(src.mux_sel)
            && pins.negative_output_pin == $past(src.sd_current);
    endproperty
    a_mode1_pins: assert property (p_mode1_pins) else $error("mode 1 pins wrong"); // RQ15

    property p_stand_pins;
        @(posedge pclk) disable iff (!presetn)
        (pclken && mode[1]) |=> pins.data_tamper_pin == $past(src.tamper)
            && pins.direction_flag_pin == $past(src.neg_power);
    endproperty
    a_stand_pins: assert property (p_stand_pins) else $error("standalone flags wrong"); // RQ16

    property p_mode3_pulse;
        @(posedge pclk) disable iff (!presetn)
        (pclken && mode == 2'h3) |=> pins.pulse_output_pin == $past(src.pulse_src[psrc]);
    endproperty
    a_mode3_pulse: assert property (p_mode3_pulse) else $error("pulse source wrong"); // RQ17

endmodule

/* verilog/osc_store.sv */
// Configuration store: shadow latches, antifuses, commands, APB access
// Operation
// (RQ1) Each bit writes temporarily to its shadow latch or permanently to its fuse.
// (RQ2) A programmed fuse never changes again and survives without supply; here presetn clears every fuse_r bit.
// (RQ3) Power-on reset and remote reset both clear every shadow latch.
// (RQ4) Fifty-six configuration bits, each a shadow latch paired with a fuse.
// (RQ5) Unprogrammed fuses read zero; only a programming command sets one.
// (RQ6) Read mode set selects shadows, cleared selects fuses.
// (RQ7) Each bit is written by one byte command.
// (RQ8) Locked: only precharge and remote reset accepted; shadows no longer used.
// (RQ9) Lock bit at address 0: zero allows test and precharge, one locks.
// (RQ10) Host should set the lock bit after configuring.
// (RQ11) Address 1 selects the lower or upper clock frequency range.
// (RQ12) Address 2 selects crystal or resistor-capacitor oscillator.
// (RQ13) Addresses 3 and 4 form the operating mode field.
// (RQ14) Mode 0: watchdog, zero crossing and energy pulses on pins.
// (RQ15) Mode 1: sigma-delta streams and channel selection on pins.
// (RQ16) Modes 2 and 3: stepper, no-load, tamper and direction flags.
// (RQ17) Mode 2 active pulses; mode 3 pulses from pulse source select.
// (RQ18) Two records of 28 data bits and four parity bits each.
// (RQ19) Selected configuration bits are shown continuously and follow changes.
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
module osc_store (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclken,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire osc_pkg::osc_src_type meter_src,
    output osc_pkg::osc_pin_type meter_pins,
    output logic [55:0] cfg_bits,
    output logic config_lock_bit,
    output logic clock_range_select,
    output logic oscillator_type_select,
    output logic [1:0] operating_mode_select,
    output logic [1:0] pulse_source_select,
    output logic test_enable,
    output logic precharge_cont,
    output logic precharge_pulse,
    output logic remote_reset_pulse
);

    // ------------------------------------------------------------
    // Parity of one record
    // ------------------------------------------------------------
    function automatic logic [31:0] rec_build(input logic [27:0] d);
        logic [3:0] p;
        p = 4'h0;
        for (int i = 0; i < osc_pkg::REC_PAR; i++) begin
            p[i] = ~(d[i] ^ d[i+4] ^ d[i+8] ^ d[i+12] ^ d[i+16] ^ d[i+20]
                ^ d[i+24]);
        end
        return {p, d};
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // (RQ4) Fifty-six paired bits
    logic [55:0] shadow_r;
    logic [55:0] fuse_r;
    logic rd_mode_r;
    logic reject_r;
    logic [7:0] cmd_r;
    logic prech_r;
    logic rreset_r;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic err_r;
    logic err_nxt;

    logic setup;
    logic access;
    logic wr_acc;
    logic cmd_wr;
    logic stat_wr;
    osc_pkg::osc_op_type op;
    logic [5:0] adr;
    logic adr_ok;
    logic allowed;
    logic shadow_ok;
    logic fuse_ok;
    logic prech_ok;
    logic rreset_ok;
    logic cmd_rej;
    logic lock;
    logic src_shadow;

    // ------------------------------------------------------------
    // Bus phases
    // ------------------------------------------------------------
    assign setup = psel && !penable && pclken;
    assign access = psel && penable && pclken;
    assign wr_acc = access && pwrite && !pslverr;
    assign pready = pclken;
    assign pslverr = psel && penable && err_r;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    // (RQ7) One byte per command
    assign cmd_wr = wr_acc && paddr == osc_pkg::OFS_CMD;
    assign stat_wr = wr_acc && paddr == osc_pkg::OFS_STAT;
    assign op = osc_pkg::osc_op_type'(pwdata[7:osc_pkg::CMD_OP_LSB]);
    assign adr = pwdata[5:0];
    assign adr_ok = adr < 6'(osc_pkg::CFG_BITS);
    // (RQ8) Lock filters writes
    assign allowed = op == osc_pkg::OP_PRECHARGE || op == osc_pkg::OP_RRESET
        || (!lock && adr_ok);
    assign shadow_ok = cmd_wr && allowed && op == osc_pkg::OP_SHADOW;
    assign fuse_ok = cmd_wr && allowed && op == osc_pkg::OP_FUSE;
    assign prech_ok = cmd_wr && op == osc_pkg::OP_PRECHARGE;
    assign rreset_ok = cmd_wr && op == osc_pkg::OP_RRESET;
    assign cmd_rej = cmd_wr && !allowed;

    // ------------------------------------------------------------
    // Lock and source
    // ------------------------------------------------------------
    // (RQ9) Fuse lock bit
    assign lock = fuse_r[osc_pkg::ADR_LOCK];
    // (RQ8) Shadows unusable locked
    assign src_shadow = rd_mode_r && !lock;
    assign test_enable = !lock;
    assign precharge_cont = !lock && !src_shadow;
    assign config_lock_bit = lock;

    // ------------------------------------------------------------
    // Shadow latches
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // (RQ3) Power-on clear
            shadow_r <= '0;
        end else if (pclken) begin
            if (rreset_ok) begin
                // (RQ3) Remote reset clear
                shadow_r <= '0;
            end else if (shadow_ok) begin
                // (RQ1) Temporary write
                shadow_r[adr] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Antifuse cells
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // (RQ5) Unprogrammed reads zero
            fuse_r <= '0;
        end else if (pclken && fuse_ok) begin
            // (RQ2) Set only, cleared only by presetn
            fuse_r[adr] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Control and status
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_mode_r <= osc_pkg::CTRL_RD_RST;
        end else if (pclken && wr_acc && paddr == osc_pkg::OFS_CTRL) begin
            rd_mode_r <= pwdata[osc_pkg::CTRL_RD_MODE];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reject_r <= 1'b0;
        end else if (pclken) begin
            reject_r <= cmd_rej || (reject_r && !(stat_wr
                && pwdata[osc_pkg::STAT_REJECT]));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_r <= osc_pkg::CMD_RST;
            prech_r <= 1'b0;
            rreset_r <= 1'b0;
        end else if (pclken) begin
            if (cmd_wr) begin
                cmd_r <= pwdata[7:0];
            end
            prech_r <= prech_ok;
            rreset_r <= rreset_ok;
        end
    end

    assign precharge_pulse = prech_r;
    assign remote_reset_pulse = rreset_r;

    // ------------------------------------------------------------
    // Selected configuration
    // ------------------------------------------------------------
    // (RQ6) Source select
    // (RQ19) Continuous output
    assign cfg_bits = src_shadow ? shadow_r : fuse_r;
    // (RQ11) Clock range
    assign clock_range_select = cfg_bits[osc_pkg::ADR_CLK_RANGE];
    // (RQ12) Oscillator type
    assign oscillator_type_select = cfg_bits[osc_pkg::ADR_OSC_TYPE];
    // (RQ13) Mode field
    assign operating_mode_select = {cfg_bits[osc_pkg::ADR_MODE_MSB],
        cfg_bits[osc_pkg::ADR_MODE_LSB]};
    assign pulse_source_select = {cfg_bits[osc_pkg::ADR_PSRC_MSB],
        cfg_bits[osc_pkg::ADR_PSRC_LSB]};

    osc_pin_mux u_pins (
        .pclk(pclk),
        .presetn(presetn),
        .pclken(pclken),
        .mode(operating_mode_select),
        .psrc(pulse_source_select),
        .src(meter_src),
        .pins(meter_pins)
    );

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        prdata_nxt = osc_pkg::RD_ZERO;
        err_nxt = 1'b0;
        case (paddr)
            osc_pkg::OFS_CMD: begin
                prdata_nxt[7:0] = cmd_r;
            end
            osc_pkg::OFS_CTRL: begin
                prdata_nxt[osc_pkg::CTRL_RD_MODE] = rd_mode_r;
            end
            osc_pkg::OFS_STAT: begin
                prdata_nxt[osc_pkg::STAT_LOCK] = lock;
                prdata_nxt[osc_pkg::STAT_SRC_SHD] = src_shadow;
                prdata_nxt[osc_pkg::STAT_REJECT] = reject_r;
                prdata_nxt[osc_pkg::STAT_TEST] = test_enable;
                prdata_nxt[osc_pkg::STAT_PRECH] = precharge_cont;
            end
            // (RQ18) Records with parity
            osc_pkg::OFS_REC_LOW: begin
                prdata_nxt = rec_build(cfg_bits[27:0]);
            end
            osc_pkg::OFS_REC_HIGH: begin
                prdata_nxt = rec_build(cfg_bits[55:28]);
            end
            osc_pkg::OFS_SHD_LOW: begin
                prdata_nxt[27:0] = shadow_r[27:0];
            end
            osc_pkg::OFS_SHD_HIGH: begin
                prdata_nxt[27:0] = shadow_r[55:28];
            end
            osc_pkg::OFS_FUSE_LOW: begin
                prdata_nxt[27:0] = fuse_r[27:0];
            end
            osc_pkg::OFS_FUSE_HIGH: begin
                prdata_nxt[27:0] = fuse_r[55:28];
            end
            default: begin
                err_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= osc_pkg::RD_ZERO;
            err_r <= 1'b0;
        end else if (setup) begin
            prdata_r <= prdata_nxt;
            err_r <= err_nxt;
        end
    end

    assign prdata = prdata_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_shadow_cmd;
        shadow_ok && !rreset_ok;
    endsequence

    sequence s_rreset_cmd;
        rreset_ok;
    endsequence

    property p_shadow_set;
        logic [5:0] a;
        @(posedge pclk) disable iff (!presetn)
        (s_shadow_cmd, a = adr) |=> shadow_r[a];
    endproperty
    a_shadow_set: assert property (p_shadow_set) else $error("shadow bit not set"); // RQ1

    property p_fuse_keep;
        @(posedge pclk) disable iff (!presetn)
        ##1 (($past(fuse_r) & ~fuse_r) == 56'h00_0000_0000_0000);
    endproperty
    a_fuse_keep: assert property (p_fuse_keep) else $error("fuse bit cleared"); // RQ2

    property p_rreset_clear;
        @(posedge pclk) disable iff (!presetn)
        s_rreset_cmd |=> shadow_r == 56'h00_0000_0000_0000 && remote_reset_pulse;
    endproperty
    a_rreset_clear: assert property (p_rreset_clear) else $error("shadows kept"); // RQ3

    property p_fuse_cause;
        @(posedge pclk) disable iff (!presetn)
        (fuse_r != $past(fuse_r)) |-> $past(fuse_ok);
    endproperty
    a_fuse_cause: assert property (p_fuse_cause) else $error("fuse set uncommanded"); // RQ5

    property p_src_mux;
        @(posedge pclk) disable iff (!presetn)
        cfg_bits == (rd_mode_r && !fuse_r[0] ? shadow_r : fuse_r);
    endproperty
    a_src_mux: assert property (p_src_mux) else $error("wrong config source"); // RQ6

    property p_lock_block;
        @(posedge pclk) disable iff (!presetn)
        (lock && cmd_wr && (op == osc_pkg::OP_SHADOW || op == osc_pkg::OP_FUSE))
            |=> $stable(fuse_r) && $stable(shadow_r) && reject_r;
    endproperty
    a_lock_block: assert property (p_lock_block) else $error("locked write taken"); // RQ8

    property p_lock_test;
        @(posedge pclk) disable iff (!presetn)
        fuse_r[0] |-> !test_enable && !src_shadow && config_lock_bit;
    endproperty
    a_lock_test: assert property (p_lock_test) else $error("lock not honoured"); // RQ9

    property p_mode_field;
        @(posedge pclk) disable iff (!presetn)
        operating_mode_select == cfg_bits[4:3] && clock_range_select == cfg_bits[1];
    endproperty
    a_mode_field: assert property (p_mode_field) else $error("field decode wrong"); // RQ13

    property p_rec_parity;
        @(posedge pclk) disable iff (!presetn)
        (setup && paddr == osc_pkg::OFS_REC_HIGH) |=>
            (^{prdata[28], prdata[24], prdata[20], prdata[16], prdata[12],
            prdata[8], prdata[4], prdata[0]}) == 1'b1;
    endproperty
    a_rec_parity: assert property (p_rec_parity) else $error("record parity even"); // RQ18

endmodule

/* tb/osc_host.sv */
// Host model issuing APB transfers to the configuration store
`timescale 1ns/1ps
module osc_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic hung = 1'h0;

    initial begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1 && n < 64) begin
            n++;
            @(posedge pclk);
        end
        if (n >= 64) hung = 1'h1;
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        pwdata <= ~d;
    endtask
endmodule

/* tb/osc_store_tb.sv */
// Self-checking bench of the configuration store
`timescale 1ns/1ps
module osc_store_tb;
    logic pclk, presetn, pclken, psel, penable, pwrite, pready, pslverr, ev, rd;
    logic lock, crs, ots, ten, pcc, pp, rrp;
    logic [1:0] oms, pss;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic [55:0] cfg_bits, sh, fu;
    osc_pkg::osc_src_type meter_src;
    osc_pkg::osc_pin_type meter_pins;
    int error_cnt, cmp_count;

    initial begin
        pclk = 1'h0;
        forever #12.5 pclk = ~pclk;
    end

    osc_store osc_store_i (
        .pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .meter_src(meter_src), .meter_pins(meter_pins),
        .cfg_bits(cfg_bits), .config_lock_bit(lock), .clock_range_select(crs),
        .oscillator_type_select(ots), .operating_mode_select(oms),
        .pulse_source_select(pss), .test_enable(ten), .precharge_cont(pcc),
        .precharge_pulse(pp), .remote_reset_pulse(rrp)
    );
    osc_host osc_host_i (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
    );

    // ------------------------------------------------------------
    // Model and checks
    // ------------------------------------------------------------
    function automatic logic [31:0] rec(input logic [27:0] d);
        logic [3:0] p;
        for (int i = 0; i < 4; i++) begin
            p[i] = ~^{d[i], d[i+4], d[i+8], d[i+12], d[i+16], d[i+20], d[i+24]};
        end
        return {p, d};
    endfunction

    function automatic osc_pkg::osc_pin_type pexp(input logic [1:0] m, input logic [1:0] ps,
            input osc_pkg::osc_src_type s);
        osc_pkg::osc_pin_type o;
        o = '0;
        if (m == 2'h0) begin
            o.negative_output_pin = s.watchdog;
            o.positive_output_pin = s.zero_crossing_out;
            o.pulse_output_pin = s.energy_pulse;
        end else if (m == 2'h1) begin
            o.positive_output_pin = s.sd_voltage;
            o.negative_output_pin = s.sd_current;
            o.pulse_output_pin = s.mux_sel;
        end else begin
            o.positive_output_pin = s.step_pos;
            o.negative_output_pin = s.step_neg;
            o.clock_noload_pin = s.no_load;
            o.data_tamper_pin = s.tamper;
            o.direction_flag_pin = s.neg_power;
            o.pulse_output_pin = (m == 2'h2) ? s.energy_pulse : s.pulse_src[ps];
        end
        return o;
    endfunction

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: %s", $time, m);
        end
    endtask

    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        osc_host_i.xfer(w, a, d, rv, ev);
        if (osc_host_i.hung) begin
            error_cnt++;
            $display("MISMATCH at %0t: bus hang", $time);
            test_done();
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string m);
        bus(1'h0, a, 32'h0000_0000);
        chk(64'(rv), 64'(x), m);
    endtask

    task automatic cmd(input logic [1:0] op, input logic [5:0] a);
        logic [55:0] e;
        bus(1'h1, osc_pkg::OFS_CMD, {24'h00_0000, op, a});
        if (op == 2'h1 && !fu[0] && a < 6'h38) sh[a] = 1'h1;
        if (op == 2'h2 && !fu[0] && a < 6'h38) fu[a] = 1'h1;
        if (op == 2'h3) sh = '0;
        e = (rd && !fu[0]) ? sh : fu;
        @(negedge pclk);
        chk(64'(cfg_bits), 64'(e), "cfg bits");
        chk(64'({lock, crs, ots, oms, pss, pp, rrp, ten, pcc}),
            64'({fu[0], e[1], e[2], e[4:3], e[49:48], op == 2'h0, op == 2'h3, !fu[0],
            !fu[0] && !rd}), "fields");
    endtask

    task automatic pin_mode(input logic [1:0] m);
        logic [1:0] ps;
        ps = 2'($urandom);
        cmd(2'h3, 6'h00);
        if (m[0]) cmd(2'h1, osc_pkg::ADR_MODE_LSB);
        if (m[1]) cmd(2'h1, osc_pkg::ADR_MODE_MSB);
        if (ps[0]) cmd(2'h1, osc_pkg::ADR_PSRC_LSB);
        if (ps[1]) cmd(2'h1, osc_pkg::ADR_PSRC_MSB);
        repeat (3) begin
            @(posedge pclk);
            meter_src <= osc_pkg::osc_src_type'(15'($urandom));
            repeat (2) @(posedge pclk);
            @(negedge pclk);
            chk(64'(meter_pins), 64'(pexp(m, ps, meter_src)), "pins");
        end
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(94071));
        {presetn, rd, error_cnt, cmp_count, sh, fu, meter_src} = '0;
        pclken = 1'h1;
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        rdc(osc_pkg::OFS_STAT, 32'h0000_0018, "reset status");
        chk(64'(cfg_bits), 64'h0, "reset cfg");
        $display("test reset done");
        bus(1'h1, osc_pkg::OFS_CTRL, 32'h0000_0001);
        rd = 1'h1;
        cmd(2'h1, osc_pkg::ADR_CLK_RANGE);
        cmd(2'h1, osc_pkg::ADR_OSC_TYPE);
        repeat (4) cmd(2'h1, 6'($urandom_range(55, 5)));
        cmd(2'h1, 6'h3c);
        cmd(2'h3, 6'h00);
        $display("test shadow done");
        for (int m = 0; m < 4; m++) pin_mode(2'(m));
        @(posedge pclk) pclken <= 1'h0;
        meter_src <= ~meter_src;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk(64'({pready, meter_pins}), 64'({1'h0, pexp(sh[4:3], sh[49:48], ~meter_src)}),
            "frozen pins");
        @(posedge pclk) pclken <= 1'h1;
        $display("test pins done");
        bus(1'h1, osc_pkg::OFS_CTRL, 32'h0000_0000);
        rd = 1'h0;
        cmd(2'h1, 6'h07);
        repeat (4) cmd(2'h2, 6'($urandom_range(55, 1)));
        cmd(2'h2, 6'h21);
        cmd(2'h2, 6'h21);
        rdc(osc_pkg::OFS_REC_LOW, rec(fu[27:0]), "record low");
        rdc(osc_pkg::OFS_REC_HIGH, rec(fu[55:28]), "record high");
        $display("test fuse done");
        cmd(2'h2, osc_pkg::ADR_LOCK);
        bus(1'h1, osc_pkg::OFS_CTRL, 32'h0000_0001);
        rd = 1'h1;
        cmd(2'h1, 6'h08);
        cmd(2'h2, 6'h09);
        cmd(2'h0, 6'h00);
        rdc(osc_pkg::OFS_STAT, 32'h0000_0005, "locked status");
        bus(1'h1, osc_pkg::OFS_STAT, 32'h0000_0004);
        cmd(2'h3, 6'h00);
        rdc(osc_pkg::OFS_STAT, 32'h0000_0001, "cleared status");
        bus(1'h0, 8'h40, 32'h0000_0000);
        chk(64'(ev), 64'h1, "unmapped error");
        $display("test lock done");
        test_done();
    end
endmodule
